// file: core/psau_regs.vh
`ifndef PSAU_REGS_VH
`define PSAU_REGS_VH
// ==========================================================
// register map (byte addresses, one aligned word each)
`define PSAU_OFF_TBLPG 4'h0
`define PSAU_OFF_WINPG 4'h4
`define PSAU_OFF_CORE 4'h8
`define PSAU_OFF_STAT 4'hC
// ==========================================================
// field positions
`define PSAU_CORE_WEN_BIT 0
`define PSAU_PAGE_CFG_BIT 7
`define PSAU_EA_MSB 15
// ==========================================================
// reset values
`define PSAU_TBLPG_RST 8'h00
`define PSAU_WINPG_RST 8'h00
`define PSAU_CORE_RST 1'b0
// ==========================================================
// access kinds
`define PSAU_K_NONE 3'h0
`define PSAU_K_RDL 3'h1
`define PSAU_K_RDH 3'h2
`define PSAU_K_WTL 3'h3
`define PSAU_K_WTH 3'h4
`define PSAU_K_DATA 3'h5
// ==========================================================
// instruction classes for the window penalty
`define PSAU_C_OTHER 2'h0
`define PSAU_C_MACPF 2'h1
`define PSAU_C_MOV 2'h2
`define PSAU_C_MOVD 2'h3
// ==========================================================
// extra cycle counts
`define PSAU_XTRA_ONE 2'h1
`define PSAU_XTRA_TWO 2'h2
// ==========================================================
// user space ceiling, last even word address
`define PSAU_USER_TOP 24'h7FFFFE
`define PSAU_RESP_OK 2'h0
`define PSAU_RESP_SLVERR 2'h2
`endif

// file: core/psau_top.v
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module psau_top (
	// clock and reset
	input wire clk,
	input wire rst,
	// axi4-lite write address and data
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// core access request
	input wire acc_valid,
	input wire [2:0] acc_kind,
	input wire acc_byte,
	input wire [15:0] acc_ea,
	input wire [22:0] acc_pc,
	input wire [15:0] acc_wdata,
	input wire [1:0] acc_class,
	input wire acc_in_repeat,
	input wire acc_rpt_edge,
	input wire tbl_busy,
	// program memory side
	input wire [23:0] pm_rdata,
	output reg [23:0] pm_addr,
	output reg pm_rd,
	output reg pm_wr,
	output reg [23:0] pm_wdata,
	output reg [2:0] pm_wmask,
	// answer to the core
	output reg [15:0] res_data,
	output reg res_valid,
	output reg res_window,
	output reg res_xspace,
	output reg [1:0] res_extra,
	output reg res_range_err
);
`include "psau_regs.vh"

	// ==========================================================
	// software registers
	reg [7:0] tbl_page_r;
	reg [7:0] win_page_r;
	reg win_en_r;
	reg range_err_r;
	reg [15:0] win_count_r;

	// ==========================================================
	// axi4-lite write: address and data taken in either order
	reg aw_held_r;
	reg w_held_r;
	reg [3:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
	wire clr_hit = wr_go && aw_addr_r == `PSAU_OFF_STAT && w_strb_r[0] && w_data_r[0];
	wire range_set;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 4'h0;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PSAU_RESP_OK;
			tbl_page_r <= `PSAU_TBLPG_RST;
			win_page_r <= `PSAU_WINPG_RST;
			win_en_r <= `PSAU_CORE_RST;
		end else begin
			s_axi_awready <= !aw_held_r && !s_axi_awready;
			s_axi_wready <= !w_held_r && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `PSAU_RESP_OK;
				case (aw_addr_r)
					`PSAU_OFF_TBLPG: begin
						if (w_strb_r[0])
							tbl_page_r <= w_data_r[7:0];
					end
					`PSAU_OFF_WINPG: begin
						if (w_strb_r[0])
							win_page_r <= w_data_r[7:0];
					end
					`PSAU_OFF_CORE: begin
						if (w_strb_r[0])
							win_en_r <= w_data_r[`PSAU_CORE_WEN_BIT];
					end
					`PSAU_OFF_STAT: ;
					default: s_axi_bresp <= `PSAU_RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// axi4-lite read, one cycle after the address is taken
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `PSAU_RESP_OK;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b0 :
				(!s_axi_rvalid && !s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `PSAU_RESP_OK;
				case (s_axi_araddr)
					`PSAU_OFF_TBLPG: s_axi_rdata <= {24'h0, tbl_page_r};
					`PSAU_OFF_WINPG: s_axi_rdata <= {24'h0, win_page_r};
					`PSAU_OFF_CORE: s_axi_rdata <= {31'h0, win_en_r};
					// status shows block state: error flag and window hit count
					`PSAU_OFF_STAT: s_axi_rdata <= {win_count_r, 15'h0, range_err_r};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `PSAU_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// access decode
	wire is_tbl_rd = acc_kind == `PSAU_K_RDL || acc_kind == `PSAU_K_RDH;
	wire is_tbl_wt = acc_kind == `PSAU_K_WTL || acc_kind == `PSAU_K_WTH;
	wire is_tbl = is_tbl_rd || is_tbl_wt;
	wire is_high = acc_kind == `PSAU_K_RDH || acc_kind == `PSAU_K_WTH;
	// window blocked while a table operation is still in flight
	wire win_hit = acc_kind == `PSAU_K_DATA && acc_ea[`PSAU_EA_MSB] && win_en_r
		&& !tbl_busy;
	wire is_fetch = acc_kind == `PSAU_K_NONE;

	// ==========================================================
	// program address construction
	reg [23:0] addr_c;
	reg [1:0] extra_c;
	always @* begin
		addr_c = 24'h0;
		if (is_tbl)
			addr_c = {tbl_page_r, acc_ea};
		else if (win_hit)
			addr_c = {1'b0, win_page_r, acc_ea[14:0]};
		else
			addr_c = {1'b0, acc_pc};
	end

	// non-table accesses must stay below the configuration half
	assign range_set = acc_valid && !is_tbl && (addr_c[23] || addr_c > `PSAU_USER_TOP);

	// window penalty
	always @* begin
		extra_c = 2'h0;
		if (win_hit) begin
			if (acc_in_repeat)
				extra_c = acc_rpt_edge ? `PSAU_XTRA_TWO : 2'h0;
			else if (acc_class == `PSAU_C_OTHER)
				extra_c = `PSAU_XTRA_TWO;
			else
				extra_c = `PSAU_XTRA_ONE;
		end
	end

	// ==========================================================
	// read lane mapping for the result of the last access
	reg rd_kind_high_r;
	reg rd_byte_r;
	reg rd_pend_r;
	reg [15:0] lane_c;
	always @* begin
		lane_c = 16'h0;
		if (rd_kind_high_r) begin
			if (rd_byte_r)
				lane_c = 16'h0;
			else
				lane_c = {8'h0, pm_rdata[23:16]};
		end else if (rd_byte_r) begin
			lane_c = {8'h0, pm_rdata[15:8]};
		end else begin
			lane_c = acc_byte_lo_sel ? 16'h0 : 16'h0;
			lane_c = rd_low_byte_r ? {8'h0, pm_rdata[7:0]} : pm_rdata[15:0];
		end
	end
	reg rd_low_byte_r;
	wire acc_byte_lo_sel = 1'b0;

	// ==========================================================
	// request register stage and result stage
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pm_addr <= 24'h0;
			pm_rd <= 1'b0;
			pm_wr <= 1'b0;
			pm_wdata <= 24'h0;
			pm_wmask <= 3'h0;
			rd_kind_high_r <= 1'b0;
			rd_byte_r <= 1'b0;
			rd_low_byte_r <= 1'b0;
			rd_pend_r <= 1'b0;
			res_data <= 16'h0;
			res_valid <= 1'b0;
			res_window <= 1'b0;
			res_xspace <= 1'b0;
			res_extra <= 2'h0;
			res_range_err <= 1'b0;
			range_err_r <= 1'b0;
			win_count_r <= 16'h0;
		end else begin
			pm_addr <= addr_c;
			pm_rd <= acc_valid && (is_tbl_rd || win_hit || is_fetch);
			pm_wr <= acc_valid && is_tbl_wt;
			// high writes touch only the upper byte lane; low writes the low word, or one byte of it when acc_byte is set
			pm_wdata <= is_high ? {acc_wdata[7:0], 16'h0} : {8'h0, acc_wdata};
			pm_wmask <= !(acc_valid && is_tbl_wt) ? 3'h0 :
				is_high ? 3'h4 : acc_byte ? (acc_ea[0] ? 3'h2 : 3'h1) : 3'h3;
			rd_kind_high_r <= acc_kind == `PSAU_K_RDH;
			rd_byte_r <= acc_byte && acc_ea[0] && acc_kind != `PSAU_K_DATA;
			rd_low_byte_r <= acc_byte && !acc_ea[0] && acc_kind != `PSAU_K_DATA;
			rd_pend_r <= acc_valid && (is_tbl_rd || win_hit);
			res_valid <= rd_pend_r;
			res_data <= rd_pend_r ? lane_c : 16'h0;
			res_window <= acc_valid && win_hit;
			// upper data half is X space whether mapped or not
			res_xspace <= acc_valid && acc_kind == `PSAU_K_DATA && acc_ea[`PSAU_EA_MSB];
			res_extra <= acc_valid ? extra_c : 2'h0;
			res_range_err <= range_set;
			// set wins over a software clear in the same cycle
			if (range_set)
				range_err_r <= 1'b1;
			else if (clr_hit)
				range_err_r <= 1'b0;
			if (acc_valid && win_hit)
				win_count_r <= win_count_r + 16'h1;
		end
	end
endmodule

// file: verif/psau_monitor.sv
`timescale 1ns/1ps
`include "psau_regs.vh"
// ==========================================================
// port checker for the access unit
module psau_top_monitor (
	// clock, reset, core request
	input wire clk, rst, acc_valid, acc_byte, acc_in_repeat, acc_rpt_edge, tbl_busy,
	input wire [2:0] acc_kind,
	input wire [15:0] acc_ea,
	input wire [22:0] acc_pc,
	input wire [1:0] acc_class,
	// memory side and answer
	input wire [23:0] pm_rdata, pm_addr,
	input wire pm_rd, pm_wr, res_valid, res_window, res_xspace,
	input wire [2:0] pm_wmask,
	input wire [15:0] res_data,
	input wire [1:0] res_extra
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// table read requests
	wire rq_l = acc_valid && acc_kind == `PSAU_K_RDL;
	wire rq_h = acc_valid && acc_kind == `PSAU_K_RDH;
	fetch_addr_a: assert property (
		acc_valid && acc_kind == `PSAU_K_NONE |=> pm_addr == {1'b0, $past(acc_pc)}) else $error("fetch address");
	tbl_addr_a: assert property (
		rq_l || rq_h |=> pm_rd && pm_addr[15:0] == $past(acc_ea)) else $error("table address");
	high_write_a: assert property (
		acc_valid && acc_kind == `PSAU_K_WTH |=> pm_wr && pm_wmask == 3'h4) else $error("high lane");
	low_word_a: assert property (
		rq_l && !acc_byte |-> ##2 res_valid && res_data == $past(pm_rdata[15:0])) else $error("low word");
	low_byte_a: assert property (
		rq_l && acc_byte |-> ##2 res_data[7:0] == ($past(acc_ea[0], 2) ?
		$past(pm_rdata[15:8]) : $past(pm_rdata[7:0]))) else $error("low byte");
	high_word_a: assert property (
		rq_h && !acc_byte |-> ##2 res_data == {8'h00, $past(pm_rdata[23:16])}) else $error("high word");
	high_byte_a: assert property (
		rq_h && acc_byte |-> ##2 res_data[7:0] == ($past(acc_ea[0], 2) ?
		8'h00 : $past(pm_rdata[23:16]))) else $error("high byte");
	win_addr_a: assert property (
		res_window |-> pm_rd && res_xspace && !pm_addr[23] && pm_addr[14:0] == $past(acc_ea[14:0]))
		else $error("window address");
	no_redirect_a: assert property (
		acc_valid && acc_kind == `PSAU_K_DATA && (!acc_ea[15] || tbl_busy) |=> !res_window && !pm_rd)
		else $error("bad redirect");
	win_data_a: assert property (
		$past(res_window) |-> res_valid && res_data == $past(pm_rdata[15:0])) else $error("window data");
	win_extra_a: assert property (
		res_window |-> res_extra == ($past(acc_in_repeat) ? ($past(acc_rpt_edge) ? 2'h2 : 2'h0) :
		($past(acc_class) == `PSAU_C_OTHER ? 2'h2 : 2'h1))) else $error("window penalty");
	cover property (res_window && res_extra == 2'h1);
	cover property (rq_h && acc_byte && acc_ea[0]);
	cover property (res_window && res_extra == 2'h0);
endmodule
bind psau_top psau_top_monitor mon (.*);

// file: verif/psau_pmem.sv
`timescale 1ns/1ps
// ==========================================================
// program memory stand-in, combinational read
module psau_pmem (
	// memory port
	input wire [23:0] pm_addr,
	input wire pm_rd,
	output logic [23:0] pm_rdata
);
	wire [23:0] wd = {pm_addr[23:16] ^ pm_addr[7:0], pm_addr[15:0] ^ 16'h5AA5};
	// inverse between reads, so a late or early capture cannot pass
	assign pm_rdata = pm_rd ? wd : ~wd;
endmodule

// file: verif/psau_top_tb.sv
`timescale 1ns/1ps
`include "psau_regs.vh"
module psau_top_tb;
	logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, acc_valid;
	logic acc_byte, acc_in_repeat, acc_rpt_edge, tbl_busy, pm_rd, pm_wr, res_valid, res_window;
	logic res_xspace, res_range_err;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, v;
	logic [1:0] s_axi_bresp, s_axi_rresp, acc_class, res_extra, rs;
	logic [2:0] acc_kind, pm_wmask;
	logic [15:0] acc_ea, acc_wdata, res_data, x, ea, e;
	logic [22:0] acc_pc;
	logic [23:0] pm_rdata, pm_addr, pm_wdata, w;
	logic [7:0] tp, wp;
	logic [31:0] q_exp[$];
	int bad_count, tests_run, i, j;
	psau_top dut (.*);
	psau_pmem pmem (.*);
	// ==========================================================
	// helpers
	function automatic logic [15:0] xs(input logic [15:0] a);
		logic [15:0] t;
		t = a ^ (a << 7);
		t = t ^ (t >> 9);
		return t ^ (t << 8);
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// one bus transfer; valids drop only after the edge that takes them
	task axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] r);
		logic ha, hw, hr, dn;
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		dn = 1'b0;
		for (n = 0; n < 100 && !dn; n++) begin
			@(negedge clk);
			ha = s_axi_awready;
			hw = s_axi_wready;
			hr = s_axi_arready;
			dn = wr ? s_axi_bvalid : s_axi_rvalid;
			q = s_axi_rdata;
			r = wr ? s_axi_bresp : s_axi_rresp;
			@(posedge clk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
			if (hr) s_axi_arvalid <= 1'b0;
			if (dn) s_axi_bready <= 1'b0;
			if (dn) s_axi_rready <= 1'b0;
		end
		if (!dn) bad_count++;
	endtask
	// one core request per cycle; m packs busy, edge, repeat, class
	task acc(input logic [2:0] k, input logic b, input logic [15:0] a, input logic [4:0] m);
		@(posedge clk);
		x = xs(x);
		acc_valid <= 1'b1;
		acc_kind <= k;
		acc_byte <= b;
		acc_ea <= a;
		acc_pc <= {x[6:0], x};
		acc_wdata <= x;
		{tbl_busy, acc_rpt_edge, acc_in_repeat, acc_class} <= m;
	endtask
	task stop;
		@(posedge clk);
		acc_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// ==========================================================
	// clock, watchdog, result watcher
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		conclude();
	end
	always @(negedge clk) begin
		if (res_valid === 1'b1 && q_exp.size() > 0) begin
			v = q_exp.pop_front();
			chk({16'h0000, res_data & v[31:16]}, {16'h0000, v[15:0]});
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		{rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
		{acc_valid, acc_byte, acc_in_repeat, acc_rpt_edge, tbl_busy} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {8'h00, 4'hF, 32'h0};
		{acc_kind, acc_class, acc_ea, acc_wdata, acc_pc} = 60'h0;
		x = 16'h003F;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 3; i++) begin
			axi(1'b0, 4'(i * 4), 32'h0, rd, rs);
			chk(rd, 32'h0);
		end
		axi(1'b0, 4'h2, 32'h0, rd, rs);
		chk({30'h0, rs}, {30'h0, `PSAU_RESP_SLVERR});
		// user then configuration page, every read kind, size and lane
		for (i = 0; i < 2; i++) begin
			x = xs(x);
			tp = {i[0], x[6:0]};
			axi(1'b1, `PSAU_OFF_TBLPG, {24'h0, tp}, rd, rs);
			axi(1'b0, `PSAU_OFF_TBLPG, 32'h0, rd, rs);
			chk(rd, {24'h0, tp});
			for (j = 0; j < 8; j++) begin
				x = xs(x);
				ea = {x[15:1], j[0] & j[1]};
				w = {tp[7:0] ^ ea[7:0], ea ^ 16'h5AA5};
				if (!j[1]) e = j[2] ? {8'h00, w[23:16]} : w[15:0];
				else e = {8'h00, j[2] ? (j[0] ? 8'h00 : w[23:16]) : (j[0] ? w[15:8] : w[7:0])};
				q_exp.push_back({j[1] ? 16'h00FF : 16'hFFFF, e});
				acc(j[2] ? `PSAU_K_RDH : `PSAU_K_RDL, j[1], ea, 5'h00);
			end
			stop();
		end
		// window reads over every class, repeat and edge combination
		x = xs(x);
		wp = x[7:0];
		axi(1'b1, `PSAU_OFF_WINPG, {24'h0, wp}, rd, rs);
		axi(1'b1, `PSAU_OFF_CORE, 32'h1, rd, rs);
		for (i = 0; i < 16; i++) begin
			ea = xs(x) | 16'h8000;
			w = {1'b0, wp, ea[14:0]} ^ {wp[7:0], 16'h5AA5};
			q_exp.push_back({16'hFFFF, w[15:0]});
			acc(`PSAU_K_DATA, 1'b0, ea, i[4:0]);
		end
		stop();
		chk(q_exp.size(), 0);
		// requests that give no read result
		acc(`PSAU_K_DATA, 1'b0, x | 16'h8000, 5'h10);
		acc(`PSAU_K_DATA, 1'b0, x & 16'h7FFF, 5'h00);
		acc(`PSAU_K_NONE, 1'b0, x, 5'h00);
		acc(`PSAU_K_WTL, 1'b0, x, 5'h00);
		acc(`PSAU_K_WTH, 1'b0, x, 5'h00);
		stop();
		conclude();
	end
endmodule
